// file: verilog/dzq_ctrl.sv
/*
 * Host-side sequencer for DDR3 termination around power-down and for ZQ
 * calibration. Drives CK, CKE, ODT and the command pins of two ranks.
 * Assumes the user only asks for power-down entry with all banks precharged
 * and that the memory clock is the system clock divided by two.
 */
`timescale 1ns/1ps
module dzq_ctrl (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // User requests
   input wire logic i_req_valid,
   input wire dzq_pkg::dzq_cmd_t i_req_cmd,
   input wire logic i_req_rank,
   output logic o_req_ready,
   // User termination control and mode
   input wire logic i_odt_req,
   input wire logic i_dll_frozen_pd,
   // User status
   output logic o_init_done,
   output logic o_zq_busy,
   output logic o_odt_uncertain,
   output logic o_odt_async,
   output logic o_rtt_settled,
   // Memory pins
   output logic o_ck,
   output logic o_ck_n,
   output logic o_dram_reset_n,
   output logic o_cke,
   output logic [dzq_pkg::RANKS-1:0] o_cs_n,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_we_n,
   output logic o_a10,
   output logic o_odt
);

   // =====================================================================
   // Decoding shared by the ready term and the sequencer
   function automatic logic cmd_ok(input dzq_pkg::dzq_state_t st, input dzq_pkg::dzq_cmd_t cmd,
                                   input logic ref_b, input logic xs_b);
      logic ok;
      ok = 1'b0;
      case (st)
         dzq_pkg::ST_IDLE: begin
            case (cmd)
               dzq_pkg::CMD_NOP: ok = 1'b1;
               dzq_pkg::CMD_PD_ENTER: ok = 1'b1;
               dzq_pkg::CMD_REFRESH: ok = !ref_b;
               dzq_pkg::CMD_SR_ENTER: ok = !ref_b;
               dzq_pkg::CMD_ZQCL: ok = !ref_b && !xs_b;
               dzq_pkg::CMD_ZQCS: ok = !ref_b && !xs_b;
               default: ok = 1'b0;
            endcase
         end
         dzq_pkg::ST_PD: ok = (cmd == dzq_pkg::CMD_PD_EXIT) || (cmd == dzq_pkg::CMD_NOP);
         dzq_pkg::ST_SR: ok = (cmd == dzq_pkg::CMD_SR_EXIT) || (cmd == dzq_pkg::CMD_NOP);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // =====================================================================
   // Memory clock divider; pins change as CK falls so the device samples mid-cycle
   logic ck_q;
   logic tick;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ck_q <= 1'b0;
      end else if (i_ce) begin
         ck_q <= ~ck_q;
      end
   end

   assign tick = i_ce && ck_q;
   assign o_ck = ck_q;
   assign o_ck_n = ~ck_q;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_dram_reset_n <= 1'b0;
      end else if (i_ce) begin
         o_dram_reset_n <= 1'b1;
      end
   end

   // =====================================================================
   // Sequencer state and timers
   dzq_pkg::dzq_state_t state;
   logic take;
   logic zq_long;
   logic zq_rank;
   logic [dzq_pkg::RANKS-1:0] init_todo;
   logic [dzq_pkg::RANKS-1:0] zql_seen;
   logic [dzq_pkg::CNT_W-1:0] zq_len;
   logic wait_load;
   logic [dzq_pkg::CNT_W-1:0] wait_value;
   logic wait_busy;
   logic ref_load;
   logic ref_busy;
   logic xs_load;
   logic xs_busy;
   logic lead;
   logic odt_next;

   assign o_req_ready = tick && cmd_ok(state, i_req_cmd, ref_busy, xs_busy);
   assign take = i_req_valid && o_req_ready;

   dzq_cnt u_wait (
      .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_tick(tick),
      .i_load(wait_load),
      .i_value(wait_value),
      .o_busy(wait_busy)
   );

   dzq_cnt u_rfc (
      .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_tick(tick),
      .i_load(ref_load),
      .i_value(dzq_pkg::N_RFC),
      .o_busy(ref_busy)
   );

   dzq_cnt u_xs (
      .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_tick(tick),
      .i_load(xs_load),
      .i_value(dzq_pkg::N_XS),
      .o_busy(xs_busy)
   );

   assign ref_load = take && (i_req_cmd == dzq_pkg::CMD_REFRESH);
   assign xs_load = take && (i_req_cmd == dzq_pkg::CMD_SR_EXIT);
   assign lead = (state == dzq_pkg::ST_PDE_LEAD) || (state == dzq_pkg::ST_PDX_LEAD);

   assign zq_len = !zq_long ? dzq_pkg::N_ZQCS : (zql_seen[zq_rank] ? dzq_pkg::N_ZQOPER : dzq_pkg::N_ZQINIT);

   always_comb begin
      wait_load = 1'b0;
      wait_value = dzq_pkg::N_RP;
      if (tick) begin
         case (state)
            dzq_pkg::ST_ZQ_PRE: begin
               wait_load = 1'b1;
               wait_value = dzq_pkg::N_RP;
            end
            dzq_pkg::ST_ZQ_TRP: begin
               wait_load = !wait_busy;
               wait_value = zq_len;
            end
            default: begin
               wait_load = take && ((i_req_cmd == dzq_pkg::CMD_PD_ENTER) || (i_req_cmd == dzq_pkg::CMD_PD_EXIT));
               wait_value = dzq_pkg::N_ANPD;
            end
         endcase
      end
   end

   // =====================================================================
   // Main sequence
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= dzq_pkg::ST_INIT;
         zq_long <= 1'b0;
         zq_rank <= 1'b0;
      end else if (tick) begin
         case (state)
            dzq_pkg::ST_INIT: begin
               if (init_todo == '0) begin
                  state <= dzq_pkg::ST_IDLE;
               end else begin
                  zq_long <= 1'b1;
                  zq_rank <= !init_todo[0];
                  state <= dzq_pkg::ST_ZQ_PRE;
               end
            end
            dzq_pkg::ST_IDLE: begin
               if (take) begin
                  case (i_req_cmd)
                     dzq_pkg::CMD_PD_ENTER: state <= dzq_pkg::ST_PDE_LEAD;
                     dzq_pkg::CMD_SR_ENTER: state <= dzq_pkg::ST_SR;
                     dzq_pkg::CMD_ZQCL, dzq_pkg::CMD_ZQCS: begin
                        zq_long <= (i_req_cmd == dzq_pkg::CMD_ZQCL);
                        zq_rank <= i_req_rank;
                        state <= dzq_pkg::ST_ZQ_PRE;
                     end
                     default: state <= dzq_pkg::ST_IDLE;
                  endcase
               end
            end
            dzq_pkg::ST_ZQ_PRE: state <= dzq_pkg::ST_ZQ_TRP;
            dzq_pkg::ST_ZQ_TRP: begin
               if (!wait_busy) begin
                  state <= dzq_pkg::ST_ZQ_RUN;
               end
            end
            dzq_pkg::ST_ZQ_RUN: begin
               if (!wait_busy) begin
                  state <= (init_todo != '0) ? dzq_pkg::ST_INIT : dzq_pkg::ST_IDLE;
               end
            end
            dzq_pkg::ST_PDE_LEAD: begin
               if (!wait_busy) begin
                  state <= dzq_pkg::ST_PD;
               end
            end
            dzq_pkg::ST_PD: begin
               if (take && i_req_cmd == dzq_pkg::CMD_PD_EXIT) begin
                  state <= dzq_pkg::ST_PDX_LEAD;
               end
            end
            dzq_pkg::ST_PDX_LEAD: begin
               if (!wait_busy) begin
                  state <= dzq_pkg::ST_IDLE;
               end
            end
            dzq_pkg::ST_SR: begin
               if (take && i_req_cmd == dzq_pkg::CMD_SR_EXIT) begin
                  state <= dzq_pkg::ST_IDLE;
               end
            end
            default: state <= dzq_pkg::ST_IDLE;
         endcase
      end
   end

   // =====================================================================
   // Per-rank calibration bookkeeping
   genvar gr;
   generate
      for (gr = 0; gr < dzq_pkg::RANKS; gr++) begin : g_rank
         always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               zql_seen[gr] <= 1'b0;
               init_todo[gr] <= 1'b1;
            end else if (tick && state == dzq_pkg::ST_ZQ_RUN && !wait_busy && zq_rank == gr) begin
               zql_seen[gr] <= zql_seen[gr] | zq_long;
               init_todo[gr] <= 1'b0;
            end
         end
      end
   endgenerate

   // =====================================================================
   // Command pins
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cs_n <= '1;
         {o_ras_n, o_cas_n, o_we_n} <= dzq_pkg::PIN_NOP;
         o_a10 <= 1'b0;
      end else if (tick) begin
         o_cs_n <= '1;
         {o_ras_n, o_cas_n, o_we_n} <= dzq_pkg::PIN_NOP;
         o_a10 <= 1'b0;
         if (state == dzq_pkg::ST_ZQ_PRE) begin
            o_cs_n[zq_rank] <= 1'b0;
            {o_ras_n, o_cas_n, o_we_n} <= dzq_pkg::PIN_PRE;
            o_a10 <= 1'b1;
         end else if (state == dzq_pkg::ST_ZQ_TRP && !wait_busy) begin
            o_cs_n[zq_rank] <= 1'b0;
            {o_ras_n, o_cas_n, o_we_n} <= dzq_pkg::PIN_ZQ;
            o_a10 <= zq_long;
         end else if (take && (i_req_cmd == dzq_pkg::CMD_REFRESH || i_req_cmd == dzq_pkg::CMD_SR_ENTER)) begin
            o_cs_n <= '0;
            {o_ras_n, o_cas_n, o_we_n} <= dzq_pkg::PIN_REF;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cke <= 1'b0;
      end else if (tick) begin
         if (state == dzq_pkg::ST_INIT) begin
            o_cke <= 1'b1;
         end else if (state == dzq_pkg::ST_PDE_LEAD && !wait_busy) begin
            o_cke <= 1'b0;
         end else if (state == dzq_pkg::ST_PDX_LEAD && !wait_busy) begin
            o_cke <= 1'b1;
         end else if (take && i_req_cmd == dzq_pkg::CMD_SR_ENTER) begin
            o_cke <= 1'b0;
         end else if (take && i_req_cmd == dzq_pkg::CMD_SR_EXIT) begin
            o_cke <= 1'b1;
         end
      end
   end

   // =====================================================================
   // Termination pin and settle estimate
   logic [dzq_pkg::CNT_W-1:0] settle;
   logic zq_active;

   assign zq_active = (state == dzq_pkg::ST_INIT) || (state == dzq_pkg::ST_ZQ_PRE) ||
                      (state == dzq_pkg::ST_ZQ_TRP) || (state == dzq_pkg::ST_ZQ_RUN);
   assign odt_next = i_odt_req && !zq_active && (state != dzq_pkg::ST_SR);
   assign o_zq_busy = zq_active;
   assign o_init_done = (state != dzq_pkg::ST_INIT) && (init_todo == '0);

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_odt <= 1'b0;
      end else if (tick) begin
         o_odt <= odt_next;
      end
   end

   // Settle is a worst case; in the uncertain window both timings must be covered
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         settle <= '0;
      end else if (tick) begin
         if (odt_next != o_odt) begin
            if (o_odt_uncertain) begin
               settle <= dzq_pkg::N_SET_UNC;
            end else if (o_odt_async) begin
               settle <= dzq_pkg::N_SET_ASYNC;
            end else begin
               settle <= dzq_pkg::N_SET_SYNC;
            end
         end else if (settle != '0) begin
            settle <= settle - 1'b1;
         end
      end
   end

   assign o_rtt_settled = (settle == '0);

   // =====================================================================
   // Transition windows
   dzq_trans u_trans (
      .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_tick(tick),
      .i_frozen(i_dll_frozen_pd),
      .i_lead(lead),
      .i_cke(o_cke),
      .i_ref_busy(ref_busy),
      .o_uncertain(o_odt_uncertain),
      .o_async(o_odt_async)
   );

endmodule

// file: pkg/dzq_pkg.sv
/*
 * Constants and types for the DDR3 termination / power-down / ZQ sequencer.
 * Assumes a 100 MHz system clock; the memory clock is made from it by a divider.
 */
package dzq_pkg;

   // =====================================================================
   // Clocking
   localparam int SYS_PERIOD_PS = 10000;
   localparam int CK_DIV = 2;
   localparam int CK_PERIOD_PS = SYS_PERIOD_PS * CK_DIV;
   localparam int RANKS = 2;
   localparam int CNT_W = 10;

   // =====================================================================
   // Latencies in memory clocks
   localparam int CWL_NCK = 5;
   localparam int AL_NCK = 0;
   localparam int WL_NCK = CWL_NCK + AL_NCK;
   localparam int ODTL_NCK = CWL_NCK + AL_NCK - 2;
   localparam logic [CNT_W-1:0] N_ANPD = CNT_W'(WL_NCK - 1);
   localparam logic [CNT_W-1:0] N_CPDED = CNT_W'(1);

   // =====================================================================
   // Times, and the clock counts derived from them (least times round up)
   localparam int T_RP_PS = 13750;
   localparam int T_RFC_PS = 260000;
   localparam int T_XS_PS = T_RFC_PS + 10000;
   localparam int T_XPDLL_PS = 24000;
   localparam int T_AONPD_MAX_PS = 8500;
   localparam logic [CNT_W-1:0] N_RP = CNT_W'((T_RP_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS);
   localparam logic [CNT_W-1:0] N_RFC = CNT_W'((T_RFC_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS);
   localparam logic [CNT_W-1:0] N_XS = CNT_W'((T_XS_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS);
   localparam logic [CNT_W-1:0] N_XPDLL = CNT_W'((T_XPDLL_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS);
   localparam logic [CNT_W-1:0] N_ZQINIT = CNT_W'(512);
   localparam logic [CNT_W-1:0] N_ZQOPER = CNT_W'(256);
   localparam logic [CNT_W-1:0] N_ZQCS = CNT_W'(64);

   // Termination settle figures: synchronous adds two clocks for tAON and half-clock skew
   localparam logic [CNT_W-1:0] N_SET_SYNC = CNT_W'(ODTL_NCK + 2);
   localparam logic [CNT_W-1:0] N_SET_ASYNC = CNT_W'((T_AONPD_MAX_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS);
   localparam logic [CNT_W-1:0] N_SET_UNC = (N_SET_SYNC > N_SET_ASYNC) ? N_SET_SYNC : N_SET_ASYNC;

   // =====================================================================
   // Pin encodings of {ras_n, cas_n, we_n}
   localparam logic [2:0] PIN_NOP = 3'h7;
   localparam logic [2:0] PIN_ZQ = 3'h6;
   localparam logic [2:0] PIN_PRE = 3'h2;
   localparam logic [2:0] PIN_REF = 3'h1;

   // =====================================================================
   // User commands and sequencer states
   typedef enum logic [2:0] {
      CMD_NOP, CMD_PD_ENTER, CMD_PD_EXIT, CMD_REFRESH,
      CMD_SR_ENTER, CMD_SR_EXIT, CMD_ZQCL, CMD_ZQCS
   } dzq_cmd_t;

   typedef enum logic [3:0] {
      ST_INIT, ST_IDLE, ST_ZQ_PRE, ST_ZQ_TRP, ST_ZQ_RUN,
      ST_PDE_LEAD, ST_PD, ST_PDX_LEAD, ST_SR
   } dzq_state_t;

endpackage

// file: verilog/dzq_cnt.sv
/*
 * Memory-clock down counter: busy until i_value ticks after a load.
 * Assumes loads happen on a tick and i_value is at least one.
 */
`timescale 1ns/1ps
module dzq_cnt (
   // Clock and control
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_tick,
   // Load
   input wire logic i_load,
   input wire logic [dzq_pkg::CNT_W-1:0] i_value,
   // Status
   output logic o_busy
);

   logic [dzq_pkg::CNT_W-1:0] count;

   // Loading value-1 lets the owner act on the tick that is i_value ticks later
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count <= '0;
      end else if (i_ce) begin
         if (i_load) begin
            count <= i_value - 1'b1;
         end else if (i_tick && count != '0) begin
            count <= count - 1'b1;
         end
      end
   end

   // Load kept out of busy: owners derive the load from busy
   assign o_busy = (count != '0);

endmodule

// file: verilog/dzq_trans.sv
/*
 * Tracks the power-down entry and exit windows in which termination may
 * answer either synchronously or asynchronously.
 * Assumes the owner raises i_lead for the WL-1 clocks before it moves CKE.
 */
`timescale 1ns/1ps
module dzq_trans (
   // Clock and control
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_tick,
   // Sequencer view
   input wire logic i_frozen,
   input wire logic i_lead,
   input wire logic i_cke,
   input wire logic i_ref_busy,
   // Status
   output logic o_uncertain,
   output logic o_async
);

   logic cke_q;
   logic ref_hold;
   logic [dzq_pkg::CNT_W-1:0] tail;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cke_q <= 1'b0;
      end else if (i_ce) begin
         cke_q <= i_cke;
      end
   end

   // =====================================================================
   // Window tail after the CKE edge
   // tail to tCPDED on entry, to tXPDLL on exit
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tail <= '0;
      end else if (i_ce) begin
         if (cke_q && !i_cke) begin
            tail <= dzq_pkg::N_CPDED;
         end else if (!cke_q && i_cke) begin
            tail <= dzq_pkg::N_XPDLL;
         end else if (i_tick && tail != '0) begin
            tail <= tail - 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ref_hold <= 1'b0;
      end else if (i_ce) begin
         if (cke_q && !i_cke) begin
            ref_hold <= i_ref_busy;
         end else if (!i_ref_busy) begin
            ref_hold <= 1'b0;
         end
      end
   end

   assign o_uncertain = i_frozen && (i_lead || cke_q != i_cke || tail != '0 || ref_hold);
   assign o_async = i_frozen && !i_cke && !o_uncertain;

endmodule

// file: testbench/dzq_monitor.sv
/*
 * Concurrent checks on the pins of the termination / ZQ sequencer.
 * Assumes it is bound to dzq_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
module dzq_monitor (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // Observed ports
   input wire logic i_dll_frozen_pd,
   input wire logic o_req_ready,
   input wire logic o_init_done,
   input wire logic o_zq_busy,
   input wire logic o_odt_uncertain,
   input wire logic o_odt_async,
   input wire logic o_ck,
   input wire logic o_ck_n,
   input wire logic o_cke,
   input wire logic [dzq_pkg::RANKS-1:0] o_cs_n,
   input wire logic o_ras_n,
   input wire logic o_cas_n,
   input wire logic o_we_n,
   input wire logic o_odt
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   // ==========================================
   // Helpers
   logic zq_cmd;
   logic pre_cmd;
   logic [7:0] q;
   assign zq_cmd = (o_cs_n != 2'h3) && ({o_ras_n, o_cas_n, o_we_n} == dzq_pkg::PIN_ZQ);
   assign pre_cmd = (o_cs_n != 2'h3) && ({o_ras_n, o_cas_n, o_we_n} == dzq_pkg::PIN_PRE);
   // Cycles since a ZQ command began; saturates so it stays cheap
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= 8'h00;
      end else if (zq_cmd) begin
         q <= 8'h01;
      end else if (q != 8'h00 && q < 8'hC8) begin
         q <= q + 8'h01;
      end
   end
   // ==========================================
   // Properties
   a_ck_pair: assert property (o_ck_n == !o_ck) else $error("ck pair not inverse");
   a_zq_cke_odt: assert property (zq_cmd |-> o_cke && !o_odt) else $error("zq with cke low or odt");
   a_zq_after_pre: assert property ($rose(zq_cmd) |-> $past(pre_cmd)) else $error("zq without precharge");
   a_zq_quiet: assert property (q > 8'h02 && q < 8'h80 |-> o_cs_n == 2'h3) else $error("channel busy in zq");
   a_zq_busy_flag: assert property (zq_cmd |-> o_zq_busy) else $error("zq busy not shown");
   a_pins_on_tick: assert property (!$stable(o_cke) || !$stable(o_cs_n) |-> $fell(o_ck))
      else $error("pin off tick");
   a_async_pd: assert property (o_odt_async |-> !o_cke && i_dll_frozen_pd && !o_odt_uncertain)
      else $error("async outside pd");
   // Self-refresh entry drops CKE with a command on the pins; only power-down entry has a lead
   a_entry_lead: assert property ($fell(o_cke) && o_cs_n == 2'h3 && i_dll_frozen_pd && o_init_done
      |-> $past(o_odt_uncertain)) else $error("no entry window");
   a_exit_tail: assert property ($rose(o_cke) && i_dll_frozen_pd && o_init_done |-> o_odt_uncertain[*2])
      else $error("no exit window");
   a_ready_tick: assert property (o_req_ready |-> o_ck && i_ce) else $error("ready off tick");
endmodule

// file: testbench/dzq_dram_model.sv
/*
 * Behavioural memory side: sees command pins, keeps ZQ windows.
 * Assumes pins stand one memory clock and are sampled at CK rising.
 */
`timescale 1ns/1ps
module dzq_dram_model (
   // Memory pins
   input wire logic i_ck,
   input wire logic i_reset_n,
   input wire logic i_cke,
   input wire logic [1:0] i_cs_n,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_we_n,
   input wire logic i_a10,
   input wire logic i_odt,
   // Status to bench
   output logic o_fault,
   output logic o_calibrating,
   output logic [7:0] o_cal_count
);
   int quiet;
   logic pre_ok;
   logic [1:0] long_seen;
   always_ff @(posedge i_ck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         quiet <= 0;
         pre_ok <= 1'b0;
         long_seen <= 2'h0;
         o_fault <= 1'b0;
         o_calibrating <= 1'b0;
         o_cal_count <= 8'h00;
      end else if (quiet != 0) begin
         quiet <= quiet - 1;
         if (i_cs_n != 2'h3 || !i_cke || i_odt) o_fault <= 1'b1;
         if (quiet == 1) o_calibrating <= 1'b0;
      end else if (i_cs_n != 2'h3) begin
         pre_ok <= ({i_ras_n, i_cas_n, i_we_n} == dzq_pkg::PIN_PRE) && i_a10;
         if ({i_ras_n, i_cas_n, i_we_n} == dzq_pkg::PIN_ZQ) begin
            if (!pre_ok) o_fault <= 1'b1;
            o_calibrating <= 1'b1;
            o_cal_count <= o_cal_count + 8'h01;
            // window length by kind and history
            if (!i_a10) quiet <= dzq_pkg::N_ZQCS - 1;
            else if (long_seen[i_cs_n[0]]) quiet <= dzq_pkg::N_ZQOPER - 1;
            else quiet <= dzq_pkg::N_ZQINIT - 1;
            if (i_a10) long_seen[i_cs_n[0]] <= 1'b1;
         end
      end
   end
endmodule

// file: testbench/tb.sv
/*
 * Self-checking bench for dzq_ctrl against a behavioural memory model.
 * Assumes the memory clock is made inside the design from i_sys_clk.
 */
`timescale 1ns/1ps
module tb;
   logic i_sys_clk, i_arst_n, i_ce, i_req_valid, i_req_rank, i_odt_req, i_dll_frozen_pd;
   dzq_pkg::dzq_cmd_t i_req_cmd;
   logic o_req_ready, o_init_done, o_zq_busy, o_odt_uncertain, o_odt_async, o_rtt_settled;
   logic o_ck, o_ck_n, o_dram_reset_n, o_cke, o_ras_n, o_cas_n, o_we_n, o_a10, o_odt, fault, cal;
   logic [1:0] o_cs_n;
   logic [7:0] cal_count;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   dzq_ctrl dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_req_valid(i_req_valid),
      .i_req_cmd(i_req_cmd), .i_req_rank(i_req_rank), .o_req_ready(o_req_ready), .i_odt_req(i_odt_req),
      .i_dll_frozen_pd(i_dll_frozen_pd), .o_init_done(o_init_done), .o_zq_busy(o_zq_busy),
      .o_odt_uncertain(o_odt_uncertain), .o_odt_async(o_odt_async), .o_rtt_settled(o_rtt_settled),
      .o_ck(o_ck), .o_ck_n(o_ck_n), .o_dram_reset_n(o_dram_reset_n), .o_cke(o_cke), .o_cs_n(o_cs_n),
      .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_a10(o_a10), .o_odt(o_odt));
   dzq_dram_model mem (.i_ck(o_ck), .i_reset_n(o_dram_reset_n), .i_cke(o_cke), .i_cs_n(o_cs_n),
      .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_a10(o_a10), .i_odt(o_odt),
      .o_fault(fault), .o_calibrating(cal), .o_cal_count(cal_count));
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = !i_sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Timeout: whole run well under this many cycles
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end
   // Issues one request and returns on the edge that takes it
   task automatic req(input dzq_pkg::dzq_cmd_t c, input logic r);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_req_valid <= 1'b1;
      i_req_cmd <= c;
      i_req_rank <= r;
      // Ready is settled mid-cycle; the following edge takes the request
      do begin
         @(negedge i_sys_clk);
         n++;
      end while (o_req_ready !== 1'b1 && n < 2000);
      @(posedge i_sys_clk);
      i_req_valid <= 1'b0;
      check(n < 2000, 1);
   endtask
   // Counts system cycles the ZQ sequence stays busy
   task automatic zq_run(input dzq_pkg::dzq_cmd_t c, input logic r, input int n_ck, input logic [7:0] cnt);
      int n;
      req(c, r);
      n = 0;
      do begin
         @(negedge i_sys_clk);
         n++;
      end while (o_zq_busy !== 1'b0 && n < 2000);
      check(n >= 2 * n_ck && n <= 2 * n_ck + 8, 1);
      check(cal_count, cnt);
      check(fault, 1'b0);
   endtask
   task automatic pd_cycle();
      int n;
      i_dll_frozen_pd <= 1'b1;
      req(dzq_pkg::CMD_PD_ENTER, 1'b0);
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check(o_odt_uncertain, 1'b1);
      n = 0;
      while (o_odt_async !== 1'b1 && n < 40) begin
         @(negedge i_sys_clk);
         n++;
      end
      check(o_cke, 1'b0);
      check(n >= 2 * dzq_pkg::WL_NCK - 2 && n < 40, 1);
      @(posedge i_sys_clk);
      i_odt_req <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      check(o_odt, 1'b1);
      check(o_rtt_settled, 1'b1);
      req(dzq_pkg::CMD_PD_EXIT, 1'b0);
      n = 0;
      while (o_cke !== 1'b1 && n < 40) begin
         @(negedge i_sys_clk);
         n++;
      end
      check(o_odt_uncertain, 1'b1);
      @(posedge i_sys_clk);
      i_odt_req <= 1'b0;
      repeat (30) @(posedge i_sys_clk);
      check({o_odt_uncertain, o_odt, o_cke}, 3'h1);
   endtask
   initial begin
      int n;
      i_arst_n = 1'b0;
      i_ce = 1'b1;
      i_req_valid = 1'b0;
      i_req_cmd = dzq_pkg::CMD_NOP;
      i_req_rank = 1'b0;
      i_odt_req = 1'b0;
      i_dll_frozen_pd = 1'b0;
      repeat (20) @(posedge i_sys_clk);
      check({o_cke, o_cs_n, o_dram_reset_n, o_zq_busy}, 5'h0D);
      i_arst_n <= 1'b1;
      n = 0;
      while (o_init_done !== 1'b1 && n < 4000) begin
         @(posedge i_sys_clk);
         n++;
      end
      check(cal_count, 8'h02);
      check(n >= 4 * dzq_pkg::N_ZQINIT && n < 4000, 1);
      zq_run(dzq_pkg::CMD_ZQCS, 1'b1, dzq_pkg::N_ZQCS, 8'h03);
      zq_run(dzq_pkg::CMD_ZQCL, 1'b0, dzq_pkg::N_ZQOPER, 8'h04);
      pd_cycle();
      req(dzq_pkg::CMD_SR_ENTER, 1'b0);
      @(posedge i_sys_clk);
      req(dzq_pkg::CMD_SR_EXIT, 1'b0);
      repeat (40) @(posedge i_sys_clk);
      check(cal_count, 8'h04);
      zq_run(dzq_pkg::CMD_ZQCS, 1'b0, dzq_pkg::N_ZQCS, 8'h05);
      end_of_test();
   end
endmodule
bind dzq_ctrl dzq_monitor mon (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
   .i_dll_frozen_pd(i_dll_frozen_pd), .o_req_ready(o_req_ready), .o_init_done(o_init_done),
   .o_zq_busy(o_zq_busy), .o_odt_uncertain(o_odt_uncertain), .o_odt_async(o_odt_async), .o_ck(o_ck),
   .o_ck_n(o_ck_n), .o_cke(o_cke), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n),
   .o_we_n(o_we_n), .o_odt(o_odt));
